// ### common/microword_pkg.sv
// Constants, register map and carrier types of the microword control decoder.
// Assumes one AHB-Lite master and a microsequencer, both on the decoder clock.
// Operation
// - Begin bit set starts a bus cycle; type bits pick read, pause, word or byte.
// - Begin bit clear starts nothing; type bit picks await-busy or restart on release.
// - Address load bit alone lets the bus address register load this microcycle.
// - Result load bit lets the ALU output into the result register.
// - Operand load bit lets the write-back output into the operand register.
// - Write field 01 low byte, 10 high byte, 11 both bytes.
// - Instruction load bit lets bus data into the instruction register.
// - Clock-off bit stops the processor clock, halting further microcycles.
// - Length code 00 or 01 gives one, 10 two, 11 three.
// - One bit enables the extension buffer register clock.
// - Four-bit branch field selects the option condition to test.
// - Counter field gives separate preset and step enables.
// - Bank clock bit clears the bank flop, returning to the basic ROM; option_entry in the same cycle sets it instead.
// - Three-bit code decodes to one seldom-used function strobe per word; code 000 gives none.
// - Flag clock field clocks negative-zero, overflow and carry separately.
// - Two-bit field selects the negative and zero flag source.
// - Three-bit field selects the carry and overflow flag source.
// - Divisor field commands load, shift right, shift left or hold.
// - Result bus source select alone never drives the bus.
// - Drive strobe puts the selected source on the result bus.
// - Float strobe drives the float source only when float option fitted.
// - Bank flop clear enables basic ROM; set enables the option ROMs.
package microword_pkg;

  localparam int W_BEGIN = 2;
  localparam int W_TYPE_LO = 0;
  localparam int C_HALT = 2;
  localparam int F_NZ = 2;
  localparam int F_V = 1;
  localparam int F_C = 0;
  localparam int N_PRESET = 1;
  localparam int N_STEP = 0;

  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] DIV_HOLD = 2'h0;
  localparam logic [1:0] DIV_LOAD = 2'h1;
  localparam logic [1:0] DIV_RIGHT = 2'h2;
  localparam logic [1:0] DIV_LEFT = 2'h3;

  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_WORDS = 12'h008;
  localparam int CTRL_FLOAT = 0;
  localparam int CTRL_RESUME = 1;
  localparam logic CTRL_FLOAT_RESET = 1'b0;
  localparam int ST_BANK = 0;
  localparam int ST_HALT = 1;
  localparam int ST_RUN = 2;
  localparam int ST_LEN = 4;

  typedef struct packed {
    logic       float_strobe;
    logic       rd_strobe;
    logic [1:0] rd_select;
    logic [1:0] divisor_ctl;
    logic [2:0] cv_select;
    logic [1:0] nz_select;
    logic [2:0] flag_clock;
    logic [2:0] misc_code;
    logic       bank_clock;
    logic [1:0] counter_ctl;
    logic [3:0] branch_select;
    logic       ext_buffer_load;
    logic [2:0] clock_field;
    logic       ir_load;
    logic [1:0] gr_write;
    logic       operand_load;
    logic       result_load;
    logic       address_load;
    logic [2:0] bus_field;
    logic [44:0] other;
  } microword_t;

  typedef enum logic [1:0] {
    XFER_READ, XFER_READ_PAUSE, XFER_WRITE_WORD, XFER_WRITE_BYTE
  } xfer_kind_t;

  typedef struct packed {
    logic       start;
    xfer_kind_t kind;
    logic       await_transfer_busy;
    logic       restart_on_release;
  } bus_req_t;

  typedef struct packed {
    logic address_reg_load;
    logic result_reg_load;
    logic operand_reg_load;
    logic low_byte_write;
    logic high_byte_write;
    logic instruction_reg_load;
    logic extension_buffer_load;
    logic counter_preset;
    logic counter_step_enable;
    logic neg_zero_flag_clock;
    logic overflow_flag_clock;
    logic carry_flag_clock;
    logic divisor_load;
    logic divisor_shift_right;
    logic divisor_shift_left;
  } strobes_t;

  typedef struct packed {
    logic [3:0] extended_branch_select;
    logic [3:0] neg_zero_source;
    logic [7:0] carry_overflow_source;
    logic [3:0] result_bus_source;
    logic [3:0] result_bus_drive;
    logic       float_result_drive;
  } selects_t;

endpackage

// ### dv/testbench.sv
// Self-checking bench for the microword control decoder.
// Assumes useq_model feeds the link and the decoder is the one AHB slave.
`timescale 1ns/1ps
module testbench;
  import microword_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hready, hresp, option_entry;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        uword_ready, uword_valid, fit;
  logic        basic_rom_enable, option_rom_enable, clock_halt;
  logic [7:0]  misc_strobe;
  logic [95:0] rv;
  microword_t  uword, w;
  bus_req_t    bus_req;
  strobes_t    strobes;
  selects_t    selects;
  int          errors, tests_run, seed, nw, last_len;

  microword_control_decode DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .uword(uword),
    .uword_valid(uword_valid), .uword_ready(uword_ready), .option_entry(option_entry),
    .bus_req(bus_req), .strobes(strobes), .selects(selects), .misc_strobe(misc_strobe),
    .basic_rom_enable(basic_rom_enable), .option_rom_enable(option_rom_enable),
    .clock_halt(clock_halt));
  useq_model seq (.hclk(hclk), .uword_ready(uword_ready), .uword(uword),
    .uword_valid(uword_valid));

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  initial begin
    #200000;
    errors++;
    test_done;
  end

  ////////////////////////////////////////////////////////////////
  task automatic cmp_port(input logic [63:0] g, input logic [63:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic test_done;
    $display("tests_run %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic wait_ready;
    do begin
      @(posedge hclk);
    end while (hready !== 1'b1);
  endtask

  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready;
    rd = hrdata;
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic run_word(input microword_t u);
    int       l;
    logic [3:0] rb;
    logic [2:0] b;
    selects_t es;
    strobes_t ss;
    b  = u.bus_field;
    l  = (u.clock_field[1:0] == 2'h3) ? 3 : (u.clock_field[1:0] == 2'h2) ? 2 : 1;
    rb = 4'h1 << u.rd_select;
    es = {u.branch_select, 4'h1 << u.nz_select, 8'h01 << u.cv_select, rb,
          u.rd_strobe ? rb : 4'h0, u.float_strobe & fit};
    ss = {u.address_load, u.result_load, u.operand_load, u.gr_write[0], u.gr_write[1],
          u.ir_load, u.ext_buffer_load, u.counter_ctl[N_PRESET], u.counter_ctl[N_STEP],
          u.flag_clock[F_NZ], u.flag_clock[F_V], u.flag_clock[F_C],
          u.divisor_ctl == DIV_LOAD, u.divisor_ctl == DIV_RIGHT, u.divisor_ctl == DIV_LEFT};
    seq.send(u);
    #1;
    cmp_port({uword_ready, selects}, {1'b0, es});
    repeat (l - 1) @(posedge hclk);
    #1;
    cmp_port({strobes, selects}, {15'h0, es});
    @(posedge hclk);
    #1;
    cmp_port(strobes, ss);
    cmp_port({bus_req.start, bus_req.await_transfer_busy, bus_req.restart_on_release},
             {b[W_BEGIN], !b[W_BEGIN] && !b[W_TYPE_LO], !b[W_BEGIN] && b[W_TYPE_LO]});
    if (b[W_BEGIN]) begin
      cmp_port(bus_req.kind, b[1:0]);
    end
    cmp_port(misc_strobe, u.misc_code == 3'h0 ? 8'h00 : 8'h01 << (u.misc_code - 3'h1));
    cmp_port(selects, 25'h0);
    cmp_port({clock_halt, uword_ready}, {u.clock_field[C_HALT], !u.clock_field[C_HALT]});
    nw++;
    last_len = l;
  endtask

  task automatic rand_run(input int n);
    repeat (n) begin
      rv = {$random(seed), $random(seed), $random(seed)};
      w = rv[81:0];
      w.clock_field[C_HALT] = 1'b0;
      w.bank_clock = 1'b0;
      run_word(w);
    end
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    seed         = 11013;
    errors       = 0;
    tests_run    = 0;
    nw           = 0;
    fit          = 1'b0;
    hresetn      = 1'b0;
    hsel         = 1'b0;
    haddr        = 32'h0;
    htrans       = 2'h0;
    hwrite       = 1'b0;
    hsize        = 3'h2;
    hwdata       = 32'h0;
    option_entry = 1'b0;
    repeat (7) @(posedge hclk);
    #1;
    cmp_port({hready, uword_ready, basic_rom_enable, option_rom_enable, clock_halt, hresp},
             6'h38);
    @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, OFF_CTRL, 32'h0, r);
    cmp_reg(r, 32'h0);
    ahb(1'b0, 12'h0fc, 32'h0, r);
    cmp_reg(r, 32'h0);
    $display("test registers done");
    rand_run(150);
    $display("test random words done");
    ahb(1'b1, OFF_CTRL, 32'h1, r);
    fit = 1'b1;
    rand_run(60);
    ahb(1'b0, OFF_STATUS, 32'h0, r);
    cmp_reg(r[5:4], last_len[1:0]);
    $display("test float option done");
    w.clock_field[C_HALT] = 1'b1;
    run_word(w);
    ahb(1'b0, OFF_STATUS, 32'h0, r);
    cmp_reg(r[ST_HALT], 1'b1);
    ahb(1'b1, OFF_CTRL, 32'h3, r);
    #1;
    cmp_port({clock_halt, uword_ready}, 2'h1);
    $display("test halt done");
    @(posedge hclk);
    option_entry <= 1'b1;
    @(posedge hclk);
    option_entry <= 1'b0;
    repeat (2) @(posedge hclk);
    #1;
    cmp_port({basic_rom_enable, option_rom_enable}, 2'h1);
    rand_run(3);
    cmp_port(option_rom_enable, 1'b1);
    w.bank_clock = 1'b1;
    run_word(w);
    repeat (2) @(posedge hclk);
    #1;
    cmp_port({basic_rom_enable, option_rom_enable}, 2'h2);
    $display("test rom bank done");
    ahb(1'b1, OFF_WORDS, rv[31:0], r);
    ahb(1'b0, OFF_WORDS, 32'h0, r);
    cmp_reg(r, nw);
    $display("test word count done");
    test_done;
  end
endmodule

// ### dv/useq_model.sv
// Microsequencer model that offers microwords on the valid/ready link.
// Assumes the decoder samples the link on the rising edge of hclk.
`timescale 1ns/1ps
module useq_model (
  // Link.
  input  wire logic                      hclk,
  input  wire logic                      uword_ready,
  output microword_pkg::microword_t      uword,
  output logic                           uword_valid
);
  import microword_pkg::*;

  initial begin
    uword       = '0;
    uword_valid = 1'b0;
  end

  // Holds the word until ready is seen, then shows its inverse.
  task automatic send(input microword_t u);
    @(posedge hclk);
    uword       <= u;
    uword_valid <= 1'b1;
    do begin
      @(posedge hclk);
    end while (uword_ready !== 1'b1);
    uword_valid <= 1'b0;
    uword       <= ~u;
  endtask
endmodule

// ### verilog/microword_control_decode.sv
// Microword control decoder with its AHB-Lite register slave.
// Assumes the microsequencer, data path and bus logic share hclk.
//
// Design decisions made here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
module microword_control_decode #(
  parameter logic [63:0] MISC_MAP = 64'h4020100804020100,
  parameter logic [15:0] NZ_MAP   = 16'h8421,
  parameter logic [63:0] CV_MAP   = 64'h8040201008040201,
  parameter logic [15:0] RD_MAP   = 16'h8421
) (
  // Clock and reset.
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  // AHB-Lite slave.
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic                         hreadyout,
  output logic                         hresp,
  output logic [31:0]                  hrdata,
  // Microsequencer.
  input  wire microword_pkg::microword_t uword,
  input  wire logic                    uword_valid,
  output logic                         uword_ready,
  input  wire logic                    option_entry,
  // Data path and bus control.
  output microword_pkg::bus_req_t      bus_req,
  output microword_pkg::strobes_t      strobes,
  output microword_pkg::selects_t      selects,
  output logic [7:0]                   misc_strobe,
  output logic                         basic_rom_enable,
  output logic                         option_rom_enable,
  output logic                         clock_halt
);
  import microword_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_RUN, S_HALT} seq_state_t;

  ////////////////////////////////////////////////////////////////////////
  // Lookup helpers and parameter checks.

  function automatic logic [7:0] pick8(input logic [63:0] map,
                                       input logic [2:0]  code);
    pick8 = map[{code, 3'h0} +: 8];
  endfunction

  function automatic logic [3:0] pick4(input logic [15:0] map,
                                       input logic [1:0]  code);
    pick4 = map[{code, 2'h0} +: 4];
  endfunction

  function automatic logic [1:0] cycles_of(input logic [1:0] code);
    cycles_of = code[1] ? code : LEN_ONE;
  endfunction

  function automatic bit map_ok(input logic [63:0] map, input int n,
                                input int w);
    int ones;
    map_ok = 1'b1;
    for (int e = 0; e < n; e++) begin
      ones = 0;
      for (int b = 0; b < w; b++) begin
        ones += int'(map[e*w+b]);
      end
      if (ones > 1) begin
        map_ok = 1'b0;
      end
    end
  endfunction

  if (!map_ok(MISC_MAP, 8, 8) || !map_ok(CV_MAP, 8, 8) ||
      !map_ok({48'h0, NZ_MAP}, 4, 4) ||
      !map_ok({48'h0, RD_MAP}, 4, 4)) begin : g_bad_map
    $error("Each select map entry may have at most one bit set.");
  end

  ////////////////////////////////////////////////////////////////////////
  // Register slave.

  logic        dp_valid;
  logic        dp_write;
  logic [11:0] dp_addr;
  logic        float_fitted;
  logic        next_dp_valid;
  logic        next_dp_write;
  logic [11:0] next_dp_addr;
  logic        next_float_fitted;
  logic [31:0] next_hrdata;
  logic [31:0] status_word;
  logic        resume;

  seq_state_t  state;
  seq_state_t  next_state;
  logic [1:0]  left;
  logic [1:0]  next_left;
  microword_t  word;
  microword_t  next_word;
  logic        bank;
  logic        next_bank;
  logic [31:0] words;
  logic [31:0] next_words;
  logic        next_uword_ready;
  logic        fire;

  always_comb begin
    status_word = 32'h0;
    status_word[ST_BANK] = bank;
    status_word[ST_HALT] = state == S_HALT;
    status_word[ST_RUN] = state == S_RUN;
    status_word[ST_LEN +: 2] = cycles_of(word.clock_field[1:0]);
    next_dp_valid = hsel && hready && htrans[1];
    next_dp_write = hwrite;
    next_dp_addr = haddr[11:0];
    next_hrdata = 32'h0;
    if (next_dp_valid && !hwrite) begin
      case (haddr[11:0])
        OFF_CTRL: next_hrdata = {31'h0, float_fitted};
        OFF_STATUS: next_hrdata = status_word;
        OFF_WORDS: next_hrdata = words;
        default: next_hrdata = 32'h0;
      endcase
    end
    next_float_fitted = float_fitted;
    resume = 1'b0;
    if (dp_valid && dp_write && dp_addr == OFF_CTRL) begin
      next_float_fitted = hwdata[CTRL_FLOAT];
      resume = hwdata[CTRL_RESUME];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= 12'h000;
      float_fitted <= CTRL_FLOAT_RESET;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      dp_valid <= next_dp_valid;
      dp_write <= next_dp_write;
      dp_addr <= next_dp_addr;
      float_fitted <= next_float_fitted;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Microcycle sequencing and bank flop.

  always_comb begin
    next_state = state;
    next_left = left;
    next_word = word;
    next_words = words;
    next_bank = bank;
    fire = 1'b0;
    case (state)
      S_IDLE: begin
        if (uword_valid) begin
          next_word = uword;
          next_left = cycles_of(uword.clock_field[1:0]) - 2'h1;
          next_state = S_RUN;
        end
      end
      S_RUN: begin
        if (left == 2'h0) begin
          fire = 1'b1;
          next_words = words + 32'h1;
          next_state = word.clock_field[C_HALT] ? S_HALT : S_IDLE;
        end else begin
          next_left = left - 2'h1;
        end
      end
      S_HALT: begin
        if (resume) begin
          next_state = S_IDLE;
        end
      end
      default: next_state = S_IDLE;
    endcase
    if (option_entry) begin
      next_bank = 1'b1;
    end else if (fire && word.bank_clock) begin
      next_bank = 1'b0;
    end
    next_uword_ready = next_state == S_IDLE;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= S_IDLE;
      left <= 2'h0;
      word <= '0;
      words <= 32'h0;
      bank <= 1'b0;
      uword_ready <= 1'b1;
    end else begin
      state <= next_state;
      left <= next_left;
      word <= next_word;
      words <= next_words;
      bank <= next_bank;
      uword_ready <= next_uword_ready;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control outputs.

  bus_req_t   next_bus_req;
  strobes_t   next_strobes;
  selects_t   next_selects;
  logic [7:0] next_misc_strobe;

  always_comb begin
    next_bus_req = '0;
    next_strobes = '0;
    next_misc_strobe = 8'h00;
    if (fire) begin
      if (word.bus_field[W_BEGIN]) begin
        next_bus_req.start = 1'b1;
        next_bus_req.kind = xfer_kind_t'(word.bus_field[1:0]);
      end else if (word.bus_field[W_TYPE_LO]) begin
        next_bus_req.restart_on_release = 1'b1;
      end else begin
        next_bus_req.await_transfer_busy = 1'b1;
      end
      next_strobes.address_reg_load = word.address_load;
      next_strobes.result_reg_load = word.result_load;
      next_strobes.operand_reg_load = word.operand_load;
      next_strobes.low_byte_write = word.gr_write[0];
      next_strobes.high_byte_write = word.gr_write[1];
      next_strobes.instruction_reg_load = word.ir_load;
      next_strobes.extension_buffer_load = word.ext_buffer_load;
      next_strobes.counter_preset = word.counter_ctl[N_PRESET];
      next_strobes.counter_step_enable = word.counter_ctl[N_STEP];
      next_strobes.neg_zero_flag_clock = word.flag_clock[F_NZ];
      next_strobes.overflow_flag_clock = word.flag_clock[F_V];
      next_strobes.carry_flag_clock = word.flag_clock[F_C];
      case (word.divisor_ctl)
        DIV_LOAD: next_strobes.divisor_load = 1'b1;
        DIV_RIGHT: next_strobes.divisor_shift_right = 1'b1;
        DIV_LEFT: next_strobes.divisor_shift_left = 1'b1;
        default: next_strobes.divisor_load = 1'b0;
      endcase
      next_misc_strobe = pick8(MISC_MAP, word.misc_code);
    end
    next_selects = '0;
    if (next_state == S_RUN) begin
      next_selects.extended_branch_select = next_word.branch_select;
      next_selects.neg_zero_source = pick4(NZ_MAP, next_word.nz_select);
      next_selects.carry_overflow_source = pick8(CV_MAP, next_word.cv_select);
      next_selects.result_bus_source = pick4(RD_MAP, next_word.rd_select);
      if (next_word.rd_strobe) begin
        next_selects.result_bus_drive = next_selects.result_bus_source;
      end
      next_selects.float_result_drive = next_word.float_strobe && next_float_fitted;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_req <= '0;
      strobes <= '0;
      selects <= '0;
      misc_strobe <= 8'h00;
      basic_rom_enable <= 1'b1;
      option_rom_enable <= 1'b0;
      clock_halt <= 1'b0;
    end else begin
      bus_req <= next_bus_req;
      strobes <= next_strobes;
      selects <= next_selects;
      misc_strobe <= next_misc_strobe;
      basic_rom_enable <= !next_bank;
      option_rom_enable <= next_bank;
      clock_halt <= next_state == S_HALT;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  bus_start_a: assert property (
    fire && word.bus_field[W_BEGIN] |=> bus_req.start
      && bus_req.kind == xfer_kind_t'($past(word.bus_field[1:0])))
    else $error("Bus cycle not started as coded.");

  bus_wait_a: assert property (
    fire && !word.bus_field[W_BEGIN] |=> !bus_req.start
      && bus_req.restart_on_release == $past(word.bus_field[W_TYPE_LO])
      && bus_req.await_transfer_busy != bus_req.restart_on_release)
    else $error("Idle bus field handled wrongly.");

  addr_load_a: assert property (
    strobes.address_reg_load |-> $past(fire) && $past(word.address_load))
    else $error("Address register loaded without its bit.");

  result_load_a: assert property (
    fire |=> strobes.result_reg_load == $past(word.result_load))
    else $error("Result register load mismatch.");

  operand_load_a: assert property (
    !fire |=> !strobes.operand_reg_load)
    else $error("Operand register loaded outside microcycle end.");

  byte_write_a: assert property (
    fire && word.gr_write == 2'h1 |=> strobes.low_byte_write
      && !strobes.high_byte_write)
    else $error("Low byte write decoded wrongly.");

  ir_load_a: assert property (
    strobes.instruction_reg_load |-> $past(word.ir_load) && $past(fire))
    else $error("Instruction register loaded without its bit.");

  halt_entry_a: assert property (
    fire && word.clock_field[C_HALT] |=> clock_halt && !uword_ready
      ##1 (clock_halt || $past(resume)))
    else $error("Clock-off did not halt.");

  len_three_a: assert property (
    uword_valid && uword_ready && uword.clock_field[1:0] == 2'h3
      |=> !uword_ready [*3] ##1 (uword_ready || clock_halt))
    else $error("Length three microcycle wrong.");

  len_one_a: assert property (
    uword_valid && uword_ready && !uword.clock_field[1]
      |=> !uword_ready ##1 (uword_ready || clock_halt))
    else $error("Length one microcycle wrong.");

  ext_buffer_a: assert property (
    fire |=> strobes.extension_buffer_load == $past(word.ext_buffer_load))
    else $error("Extension buffer load mismatch.");

  branch_sel_a: assert property (
    state == S_RUN |-> selects.extended_branch_select == word.branch_select)
    else $error("Branch select not held during microcycle.");

  counter_ctl_a: assert property (
    fire |=> {strobes.counter_preset, strobes.counter_step_enable}
      == $past(word.counter_ctl))
    else $error("Counter controls mismatch.");

  bank_clear_a: assert property (
    fire && word.bank_clock && !option_entry
      |=> basic_rom_enable && !option_rom_enable)
    else $error("Bank flop not cleared.");

  misc_one_a: assert property (
    misc_strobe != 8'h00 |-> $onehot(misc_strobe) && $past(fire))
    else $error("Misc strobes not single or untimely.");

  flag_clock_a: assert property (
    fire |=> {strobes.neg_zero_flag_clock, strobes.overflow_flag_clock,
      strobes.carry_flag_clock} == $past(word.flag_clock))
    else $error("Flag clocks mismatch.");

  nz_source_a: assert property (
    state == S_RUN |-> selects.neg_zero_source == pick4(NZ_MAP, word.nz_select))
    else $error("Negative-zero source wrong.");

  cv_source_a: assert property (
    state == S_RUN
      |-> selects.carry_overflow_source == pick8(CV_MAP, word.cv_select))
    else $error("Carry-overflow source wrong.");

  divisor_ctl_a: assert property (
    fire && word.divisor_ctl == DIV_HOLD |=> !strobes.divisor_load
      && !strobes.divisor_shift_right && !strobes.divisor_shift_left)
    else $error("Divisor moved on hold.");

  select_only_a: assert property (
    state == S_RUN && !word.rd_strobe |-> selects.result_bus_drive == 4'h0)
    else $error("Result bus driven without strobe.");

  bus_drive_a: assert property (
    state == S_RUN && word.rd_strobe
      |-> selects.result_bus_drive == selects.result_bus_source)
    else $error("Result bus drive not selected source.");

  float_drive_a: assert property (
    selects.float_result_drive |-> float_fitted && word.float_strobe
      && state == S_RUN)
    else $error("Float source driven without option.");

  rom_enable_a: assert property (
    option_entry |=> option_rom_enable && !basic_rom_enable)
    else $error("Option ROM not enabled on entry.");

endmodule
